// ===== shared/mcuit_consts.svh
/*
  timing and port constants for the instruction timing and port access block.
  assumes inclusion by the design module only; the package does not include it.
*/
`ifndef MCUIT_CONSTS_SVH
`define MCUIT_CONSTS_SVH
// ----------------------------------------
// instruction lengths in bytes
// ----------------------------------------
`define MCUIT_LEN_ONE 2'h1
`define MCUIT_LEN_TWO 2'h2
`define MCUIT_LEN_THREE 2'h3
// ----------------------------------------
// execution times in core clock cycles
// ----------------------------------------
`define MCUIT_CYC_ONE 3'h1
`define MCUIT_CYC_TWO 3'h2
`define MCUIT_CYC_THREE 3'h3
`define MCUIT_CYC_FOUR 3'h4
// ----------------------------------------
// port latch reset value
// ----------------------------------------
`define MCUIT_LATCH_RESET 8'hff
`endif

// ===== shared/mcuit_pkg.sv
/*
  types of the instruction timing and port access block.
  assumes mcuit_consts.svh is on the include path.
*/
package mcuit_pkg;
  // ----------------------------------------
  // instruction timing classes
  // ----------------------------------------
  typedef enum logic [4:0] {
    CLS_NOP = 5'h00,
    CLS_ACC_REG_MOVE = 5'h01,
    CLS_ACC_IND_MOVE = 5'h02,
    CLS_DIRECT_MOVE = 5'h03,
    CLS_DIR_DIR_MOVE = 5'h04,
    CLS_DATA_POINTER_LOAD = 5'h05,
    CLS_CODE_LOAD = 5'h06,
    CLS_EXT_MOVE = 5'h07,
    CLS_STACK = 5'h08,
    CLS_XCH_REG = 5'h09,
    CLS_XCH_IND = 5'h0a,
    CLS_XCH_DIR = 5'h0b,
    CLS_CARRY_BOOL = 5'h0c,
    CLS_BIT_BOOL = 5'h0d,
    CLS_SHORT_JUMP = 5'h0e,
    CLS_DECREMENT_BRANCH_NONZERO_REG = 5'h0f,
    CLS_LONG_JUMP = 5'h10,
    CLS_BIT_JUMP = 5'h11,
    CLS_COMPARE_JUMP_NOT_EQUAL = 5'h12,
    CLS_DECREMENT_BRANCH_NONZERO_DIR = 5'h13,
    CLS_JMP_IND = 5'h14,
    CLS_RETURN = 5'h15,
    CLS_ABS_JUMP = 5'h16
  } mcuit_class_t;
  // ----------------------------------------
  // port operations applied at retirement
  // ----------------------------------------
  typedef enum logic [3:0] {
    POP_NONE = 4'h0,
    POP_READ_BYTE = 4'h1,
    POP_READ_BIT = 4'h2,
    POP_WRITE = 4'h3,
    POP_AND = 4'h4,
    POP_OR = 4'h5,
    POP_XOR = 4'h6,
    POP_INC = 4'h7,
    POP_DEC = 4'h8,
    POP_DECREMENT_BRANCH_NONZERO = 4'h9,
    POP_JBC = 4'ha,
    POP_CPL_BIT = 4'hb,
    POP_MOV_C_BIT = 4'hc,
    POP_CLR_BIT = 4'hd,
    POP_SET_BIT = 4'he
  } mcuit_port_op_t;
  typedef enum logic [0:0] {
    ST_IDLE = 1'h0,
    ST_EXEC = 1'h1
  } mcuit_state_t;
endpackage

// ===== design/mcuit_core_timing.sv
/*
  instruction sequencer timing and port latch access of the 8-bit core.
  assumes the decoder in front hands over a timing class and a port operation
  per instruction on the core clock; port pins arrive asynchronously.
*/
// Function
// - code memory loads: one byte, four cycles
// - extended data moves: one byte, four cycles
// - data pointer immediate load: three bytes, three cycles
// - accumulator register/indirect moves: one byte, 1/2 cycles
// - direct byte moves: two bytes, two cycles
// - direct-to-direct or immediate-to-direct: three bytes, three
// - push and pop: two bytes, two cycles
// - exchanges take one or two cycles
// - carry ops one cycle, bit ops two
// - short and conditional jumps: two bytes, three cycles
// - register decrement branch: two bytes, three cycles
// - long jump and call: three bytes, four
// - bit jumps three bytes four; set-and-clear clears bit
// - compare jump not equal: three bytes, four cycles
// - direct decrement branch: three bytes, four cycles
// - indirect jump 2, returns 4, absolute 3
// - plain port input reads the pin
// - port read-modify-write reads latch, writes latch
// - latch-reading class of operations
// - bit writes alter only addressed latch bit
`timescale 1ns/1ps
`include "mcuit_consts.svh"
module mcuit_core_timing #(
  parameter int PORT_W = 8
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic instr_valid_i,
  input wire mcuit_pkg::mcuit_class_t instr_class_i,
  input wire mcuit_pkg::mcuit_port_op_t port_op_i,
  input wire logic [PORT_W-1:0] operand_i,
  input wire logic [$clog2(PORT_W)-1:0] bit_sel_i,
  input wire logic carry_i,
  input wire logic [PORT_W-1:0] port_pins_i,
  output logic instr_ready_o,
  output logic busy_o,
  output logic done_o,
  output logic [1:0] bytes_o,
  output logic [2:0] cycles_o,
  output logic [PORT_W-1:0] port_latch_o,
  output logic [PORT_W-1:0] read_data_o,
  output logic branch_o
);
  import mcuit_pkg::*;

  localparam int SEL_W = $clog2(PORT_W);

  if (PORT_W < 2 || PORT_W > 16) begin
    $error("PORT_W must lie between 2 and 16");
  end

  // ----------------------------------------
  // timing lookup
  // ----------------------------------------
  function automatic logic [4:0] timing_of(input mcuit_class_t cls);
    logic [1:0] len;
    logic [2:0] cyc;
    len = `MCUIT_LEN_ONE;
    cyc = `MCUIT_CYC_ONE;
    case (cls)
      CLS_NOP, CLS_ACC_REG_MOVE, CLS_XCH_REG, CLS_CARRY_BOOL: begin
        len = `MCUIT_LEN_ONE;
        cyc = `MCUIT_CYC_ONE;
      end
      CLS_ACC_IND_MOVE, CLS_XCH_IND, CLS_JMP_IND: begin
        len = `MCUIT_LEN_ONE;
        cyc = `MCUIT_CYC_TWO;
      end
      CLS_DIRECT_MOVE, CLS_STACK, CLS_XCH_DIR, CLS_BIT_BOOL: begin
        len = `MCUIT_LEN_TWO;
        cyc = `MCUIT_CYC_TWO;
      end
      CLS_DIR_DIR_MOVE, CLS_DATA_POINTER_LOAD: begin
        len = `MCUIT_LEN_THREE;
        cyc = `MCUIT_CYC_THREE;
      end
      CLS_CODE_LOAD, CLS_EXT_MOVE, CLS_RETURN: begin
        len = `MCUIT_LEN_ONE;
        cyc = `MCUIT_CYC_FOUR;
      end
      CLS_SHORT_JUMP, CLS_DECREMENT_BRANCH_NONZERO_REG, CLS_ABS_JUMP: begin
        len = `MCUIT_LEN_TWO;
        cyc = `MCUIT_CYC_THREE;
      end
      CLS_LONG_JUMP, CLS_BIT_JUMP, CLS_COMPARE_JUMP_NOT_EQUAL, CLS_DECREMENT_BRANCH_NONZERO_DIR: begin
        len = `MCUIT_LEN_THREE;
        cyc = `MCUIT_CYC_FOUR;
      end
      default: begin
        len = `MCUIT_LEN_ONE;
        cyc = `MCUIT_CYC_ONE;
      end
    endcase
    return {len, cyc};
  endfunction

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  logic [PORT_W-1:0] pin_meta;
  logic [PORT_W-1:0] pin_sync;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= port_pins_i;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  mcuit_state_t state, next_state;
  logic [2:0] count, next_count;
  logic next_ready, next_done;
  logic [1:0] next_bytes;
  logic [2:0] next_cycles;
  mcuit_port_op_t op, next_op;
  logic [PORT_W-1:0] opnd, next_opnd;
  logic [SEL_W-1:0] sel, next_sel;
  logic cin, next_cin;
  logic accept, retire;

  assign accept = instr_valid_i && instr_ready_o;
  assign retire = (state == ST_EXEC) && (count == 3'h0);

  always_comb begin
    logic [4:0] t;
    t = timing_of(instr_class_i);
    next_state = state;
    next_count = count;
    next_bytes = bytes_o;
    next_cycles = cycles_o;
    next_op = op;
    next_opnd = opnd;
    next_sel = sel;
    next_cin = cin;
    next_done = retire;
    if (accept) begin
      next_state = ST_EXEC;
      next_count = t[2:0] - 3'h1;
      next_bytes = t[4:3];
      next_cycles = t[2:0];
      // a no-operation never carries a port effect
      next_op = (instr_class_i == CLS_NOP) ? POP_NONE : port_op_i;
      next_opnd = operand_i;
      next_sel = bit_sel_i;
      next_cin = carry_i;
    end else if (retire) begin
      next_state = ST_IDLE;
    end else if (state == ST_EXEC) begin
      next_count = count - 3'h1;
    end
    // fetch reopens only in the last cycle of the running instruction
    next_ready = (next_state == ST_IDLE) || (next_count == 3'h0);
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      count <= 3'h0;
      instr_ready_o <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      bytes_o <= 2'h0;
      cycles_o <= 3'h0;
      op <= POP_NONE;
      opnd <= '0;
      sel <= '0;
      cin <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      instr_ready_o <= next_ready;
      busy_o <= (next_state == ST_EXEC);
      done_o <= next_done;
      bytes_o <= next_bytes;
      cycles_o <= next_cycles;
      op <= next_op;
      opnd <= next_opnd;
      sel <= next_sel;
      cin <= next_cin;
    end
  end

  // ----------------------------------------
  // port access at retirement
  // ----------------------------------------
  logic [PORT_W-1:0] latch_next, rdata_next;
  logic branch_next;

  always_comb begin
    logic [PORT_W-1:0] mask;
    logic [PORT_W-1:0] dec;
    mask = '0;
    mask[sel] = 1'b1;
    dec = port_latch_o - 1'b1;
    latch_next = port_latch_o;
    rdata_next = read_data_o;
    branch_next = branch_o;
    if (retire) begin
      branch_next = 1'b0;
      case (op)
        POP_READ_BYTE: rdata_next = pin_sync;
        POP_READ_BIT: rdata_next = {{(PORT_W-1){1'b0}}, |(pin_sync & mask)};
        POP_WRITE: latch_next = opnd;
        // the operand below is always the latch, so a loaded pin cannot corrupt it
        POP_AND: latch_next = port_latch_o & opnd;
        POP_OR: latch_next = port_latch_o | opnd;
        POP_XOR: latch_next = port_latch_o ^ opnd;
        POP_INC: latch_next = port_latch_o + 1'b1;
        POP_DEC: latch_next = dec;
        POP_DECREMENT_BRANCH_NONZERO: begin
          latch_next = dec;
          branch_next = |dec;
        end
        POP_JBC: begin
          branch_next = |(port_latch_o & mask);
          latch_next = port_latch_o & ~mask;
        end
        POP_CPL_BIT: latch_next = port_latch_o ^ mask;
        POP_MOV_C_BIT: begin
          latch_next = cin ? (port_latch_o | mask) : (port_latch_o & ~mask);
        end
        POP_CLR_BIT: latch_next = port_latch_o & ~mask;
        POP_SET_BIT: latch_next = port_latch_o | mask;
        default: latch_next = port_latch_o;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      port_latch_o <= PORT_W'(`MCUIT_LATCH_RESET);
      read_data_o <= '0;
      branch_o <= 1'b0;
    end else begin
      port_latch_o <= latch_next;
      read_data_o <= rdata_next;
      branch_o <= branch_next;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  property p_code_load;
    accept && instr_class_i == CLS_CODE_LOAD |=> bytes_o == 2'h1 ##1 !done_o[*3] ##1 done_o;
  endproperty
  a_code_load: assert property (p_code_load) else $error("code load not four cycles");

  property p_ext_move;
    accept && instr_class_i == CLS_EXT_MOVE |=> bytes_o == 2'h1 ##3 instr_ready_o ##1 done_o;
  endproperty
  a_ext_move: assert property (p_ext_move) else $error("extended move timing wrong");

  property p_three_cycle;
    accept && instr_class_i inside {CLS_DATA_POINTER_LOAD, CLS_DIR_DIR_MOVE}
      |=> bytes_o == 2'h3 ##2 instr_ready_o ##1 done_o;
  endproperty
  a_three_cycle: assert property (p_three_cycle) else $error("three-cycle move wrong");

  property p_one_cycle;
    accept && instr_class_i inside {CLS_NOP, CLS_ACC_REG_MOVE, CLS_XCH_REG, CLS_CARRY_BOOL}
      |=> instr_ready_o ##1 done_o;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("one-cycle op wrong");

  property p_jump_three;
    accept && instr_class_i inside {CLS_SHORT_JUMP, CLS_DECREMENT_BRANCH_NONZERO_REG, CLS_ABS_JUMP}
      |=> bytes_o == 2'h2 && cycles_o == 3'h3 ##3 done_o;
  endproperty
  a_jump_three: assert property (p_jump_three) else $error("short jump timing wrong");

  property p_long_four;
    accept && instr_class_i inside {CLS_LONG_JUMP, CLS_BIT_JUMP, CLS_COMPARE_JUMP_NOT_EQUAL, CLS_DECREMENT_BRANCH_NONZERO_DIR}
      |=> bytes_o == 2'h3 && cycles_o == 3'h4 ##4 done_o;
  endproperty
  a_long_four: assert property (p_long_four) else $error("long branch timing wrong");

  property p_two_cycle;
    accept && instr_class_i inside {CLS_DIRECT_MOVE, CLS_STACK, CLS_BIT_BOOL, CLS_JMP_IND}
      |=> !instr_ready_o ##1 instr_ready_o ##1 done_o;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("two-cycle op wrong");

  property p_stall;
    state == ST_EXEC && count != 3'h0 |-> !instr_ready_o;
  endproperty
  a_stall: assert property (p_stall) else $error("fetch open during execution");

  property p_pin_read;
    retire && op == POP_READ_BYTE |=> read_data_o == $past(pin_sync) && $stable(port_latch_o);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("port input not from pin");

  property p_latch_and;
    retire && op == POP_AND |=> port_latch_o == ($past(port_latch_o) & $past(opnd));
  endproperty
  a_latch_and: assert property (p_latch_and) else $error("and not taken from latch");

  property p_bit_only;
    retire && op inside {POP_SET_BIT, POP_CLR_BIT, POP_MOV_C_BIT}
      |=> ((port_latch_o ^ $past(port_latch_o)) & ~(PORT_W'(1) << $past(sel))) == '0;
  endproperty
  a_bit_only: assert property (p_bit_only) else $error("bit write disturbed other bits");

  c_back_to_back: cover property (accept ##1 accept);
  c_long_stall: cover property (accept && instr_class_i == CLS_CODE_LOAD ##1 instr_valid_i[*3]);
  c_jbc_taken: cover property (retire && op == POP_JBC ##1 branch_o);
endmodule

// ===== verification/mcuit_pin_model.sv
/*
  port pin model: an external load on each port pin.
  assumes the block's port latch drives the pins through a weak pull-up.
*/
`timescale 1ns/1ps
module mcuit_pin_model (
  input wire logic [7:0] latch_i,
  input wire logic [7:0] load_i,
  output logic [7:0] pins_o
);
  // ----------------------------------------
  // pin level
  // ----------------------------------------
  // a loaded pin (e.g. a transistor base) reads low even with latch at 1
  assign pins_o = latch_i & ~load_i;
endmodule

// ===== verification/mcuit_core_timing_tb.sv
/*
  self-checking bench for the instruction timing and port access block.
  assumes the pin model above sits between the port latch and the pin inputs.
*/
`timescale 1ns/1ps
module mcuit_core_timing_tb;
  import mcuit_pkg::*;
  logic clock_i, sys_rst_i, instr_valid_i, carry_i;
  mcuit_class_t instr_class_i;
  mcuit_port_op_t port_op_i;
  logic [7:0] operand_i, port_pins, port_latch, read_data, load_mask;
  logic [2:0] bit_sel_i, cycles_o;
  logic [1:0] bytes_o;
  logic ready, busy, done, branch;
  int errors, samples_checked, busy_n;
  logic [7:0] model_latch;
  logic [1:0] len_tab [23] = '{1,1,1,2,3,3,1,1,2,1,1,2,1,2,2,2,3,3,3,3,1,1,2};
  logic [2:0] cyc_tab [23] = '{1,1,2,2,3,3,4,4,2,1,2,2,1,2,3,3,4,4,4,4,2,4,3};

  mcuit_core_timing #(.PORT_W(8)) DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .instr_valid_i(instr_valid_i), .instr_class_i(instr_class_i), .port_op_i(port_op_i),
    .operand_i(operand_i), .bit_sel_i(bit_sel_i), .carry_i(carry_i),
    .port_pins_i(port_pins), .instr_ready_o(ready), .busy_o(busy), .done_o(done),
    .bytes_o(bytes_o), .cycles_o(cycles_o), .port_latch_o(port_latch),
    .read_data_o(read_data), .branch_o(branch));
  mcuit_pin_model u_pins (.latch_i(port_latch), .load_i(load_mask), .pins_o(port_pins));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checked=%0d mismatches=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // offers one instruction, then reports the negedge index of ready and done
  task automatic issue(input mcuit_class_t cls, input mcuit_port_op_t op,
      input logic [7:0] v, input logic [2:0] s, input logic cy,
      output int rdy_at, output int done_at);
    int i;
    i = 0;
    rdy_at = 0;
    done_at = 0;
    busy_n = 0;
    while (ready !== 1'b1 && i < 20) begin
      @(negedge clock_i);
      i++;
    end
    @(posedge clock_i);
    instr_valid_i <= 1'b1;
    instr_class_i <= cls;
    port_op_i <= op;
    operand_i <= v;
    bit_sel_i <= s;
    carry_i <= cy;
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    for (i = 1; i <= 8; i++) begin
      @(negedge clock_i);
      if (rdy_at == 0 && ready === 1'b1) rdy_at = i;
      if (done_at == 0 && done === 1'b1) done_at = i;
      if (busy === 1'b1) busy_n++;
    end
  endtask

  function automatic logic [7:0] ref_latch(input mcuit_port_op_t op, input logic [7:0] l,
      input logic [7:0] v, input logic [2:0] s, input logic cy);
    logic [7:0] r;
    r = l;
    case (op)
      POP_WRITE: r = v;
      POP_AND: r = l & v;
      POP_OR: r = l | v;
      POP_XOR: r = l ^ v;
      POP_INC: r = l + 8'h1;
      POP_DEC, POP_DECREMENT_BRANCH_NONZERO: r = l - 8'h1;
      POP_JBC, POP_CLR_BIT: r[s] = 1'b0;
      POP_SET_BIT: r[s] = 1'b1;
      POP_CPL_BIT: r[s] = ~l[s];
      POP_MOV_C_BIT: r[s] = cy;
      default: r = l;
    endcase
    return r;
  endfunction

  task automatic run_op(input mcuit_port_op_t op, input logic [7:0] v,
      input logic [2:0] s, input logic cy);
    int r, d;
    logic [7:0] exp_l;
    logic exp_b;
    exp_b = (op == POP_DECREMENT_BRANCH_NONZERO) ? ((model_latch - 8'h1) != 8'h0) :
            (op == POP_JBC) ? model_latch[s] : 1'b0;
    exp_l = ref_latch(op, model_latch, v, s, cy);
    issue(CLS_BIT_BOOL, op, v, s, cy, r, d);
    model_latch = exp_l;
    check(port_latch, exp_l);
    check({7'h0, branch}, {7'h0, exp_b});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_timing;
    int r, d;
    for (int c = 0; c < 23; c++) begin
      issue(mcuit_class_t'(c), POP_NONE, 8'h00, 3'h0, 1'b0, r, d);
      check({6'h0, bytes_o}, {6'h0, len_tab[c]});
      check({5'h0, cycles_o}, {5'h0, cyc_tab[c]});
      check(8'(r), {5'h0, cyc_tab[c]});
      check(8'(busy_n), {5'h0, cyc_tab[c]});
      check(8'(d), {5'h0, cyc_tab[c]} + 8'h1);
    end
    $display("test_timing finished");
  endtask

  // every pin held low by the load, so a pin read would corrupt the latch
  task automatic test_rmw;
    @(posedge clock_i);
    load_mask <= 8'hff;
    run_op(POP_AND, 8'h3c, 3'h0, 1'b0);
    run_op(POP_OR, 8'h41, 3'h0, 1'b0);
    run_op(POP_XOR, 8'h0f, 3'h0, 1'b0);
    run_op(POP_INC, 8'h00, 3'h0, 1'b0);
    run_op(POP_DEC, 8'h00, 3'h0, 1'b0);
    run_op(POP_DECREMENT_BRANCH_NONZERO, 8'h00, 3'h0, 1'b0);
    run_op(POP_WRITE, 8'h01, 3'h0, 1'b0);
    run_op(POP_DECREMENT_BRANCH_NONZERO, 8'h00, 3'h0, 1'b0);
    run_op(POP_WRITE, 8'h84, 3'h0, 1'b0);
    run_op(POP_JBC, 8'h00, 3'h2, 1'b0);
    run_op(POP_JBC, 8'h00, 3'h2, 1'b0);
    run_op(POP_CPL_BIT, 8'h00, 3'h0, 1'b0);
    run_op(POP_CLR_BIT, 8'h00, 3'h7, 1'b0);
    run_op(POP_SET_BIT, 8'h00, 3'h4, 1'b0);
    run_op(POP_MOV_C_BIT, 8'h00, 3'h1, 1'b1);
    run_op(POP_MOV_C_BIT, 8'h00, 3'h4, 1'b0);
    $display("test_rmw finished");
  endtask

  task automatic test_pin_read;
    int r, d;
    @(posedge clock_i);
    load_mask <= 8'h0f;
    run_op(POP_WRITE, 8'hff, 3'h0, 1'b0);
    issue(CLS_DIRECT_MOVE, POP_READ_BYTE, 8'h00, 3'h0, 1'b0, r, d);
    check(read_data, 8'hf0);
    issue(CLS_BIT_BOOL, POP_READ_BIT, 8'h00, 3'h4, 1'b0, r, d);
    check(read_data, 8'h01);
    issue(CLS_BIT_BOOL, POP_READ_BIT, 8'h00, 3'h0, 1'b0, r, d);
    check(read_data, 8'h00);
    check(port_latch, 8'hff);
    issue(CLS_NOP, POP_WRITE, 8'h5a, 3'h0, 1'b0, r, d);
    check(port_latch, 8'hff);
    check(read_data, 8'h00);
    $display("test_pin_read finished");
  endtask

  // offer held through a closed fetch must be ignored, then taken back to back
  task automatic test_refuse;
    while (ready !== 1'b1) @(negedge clock_i);
    @(posedge clock_i);
    instr_valid_i <= 1'b1;
    instr_class_i <= CLS_CODE_LOAD;
    port_op_i <= POP_WRITE;
    operand_i <= 8'h11;
    @(posedge clock_i);
    instr_class_i <= CLS_ACC_REG_MOVE;
    operand_i <= 8'h22;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    check({7'h0, ready}, 8'h01);
    check(port_latch, 8'hff);
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    @(negedge clock_i);
    check(port_latch, 8'h11);
    check({7'h0, done}, 8'h01);
    @(negedge clock_i);
    check(port_latch, 8'h22);
    check({5'h0, cycles_o}, 8'h01);
    check({7'h0, done}, 8'h01);
    $display("test_refuse finished");
  endtask

  initial begin
    #100000;
    errors++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
    finish_test();
  end

  initial begin
    errors = 0;
    samples_checked = 0;
    sys_rst_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_class_i = CLS_NOP;
    port_op_i = POP_NONE;
    operand_i = 8'h00;
    bit_sel_i = 3'h0;
    carry_i = 1'b0;
    load_mask = 8'h00;
    model_latch = 8'hff;
    repeat (3) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(negedge clock_i);
    check(port_latch, 8'hff);
    check({6'h0, busy, done}, 8'h00);
    $display("test_reset finished");
    test_timing();
    test_rmw();
    test_pin_read();
    test_refuse();
    finish_test();
  end
endmodule
